/* hdl/mdr_pkg.sv */
// package of register map, field layouts and types for the motion detect register bank
package mdr_pkg;

    // ****************************************************************
    // register addresses
    // ****************************************************************
    localparam logic [7:0] ADDR_Y_ACCEL_LOW = 8'h10;
    localparam logic [7:0] ADDR_Y_ACCEL_HIGH = 8'h11;
    localparam logic [7:0] ADDR_Z_ACCEL_LOW = 8'h12;
    localparam logic [7:0] ADDR_Z_ACCEL_HIGH = 8'h13;
    localparam logic [7:0] ADDR_TEMPERATURE_LOW = 8'h14;
    localparam logic [7:0] ADDR_TEMPERATURE_HIGH = 8'h15;
    localparam logic [7:0] ADDR_RESET_COMMAND = 8'h1f;
    localparam logic [7:0] ADDR_MOTION_LIMIT_LOW = 8'h20;
    localparam logic [7:0] ADDR_MOTION_LIMIT_HIGH = 8'h21;
    localparam logic [7:0] ADDR_MOTION_SAMPLE_COUNT = 8'h22;
    localparam logic [7:0] ADDR_STILLNESS_LIMIT_LOW = 8'h23;
    localparam logic [7:0] ADDR_STILLNESS_LIMIT_HIGH = 8'h24;
    localparam logic [7:0] ADDR_STILLNESS_COUNT_LOW = 8'h25;
    localparam logic [7:0] ADDR_STILLNESS_COUNT_HIGH = 8'h26;

    // ****************************************************************
    // codes, widths and field layout
    // ****************************************************************
    localparam logic [7:0] SOFT_RESET_CODE = 8'h52;
    localparam logic [7:0] READ_AS_ZERO = 8'h00;
    localparam int SAMPLE_W = 12;
    localparam int LIMIT_W = 11;
    localparam int MOTION_TIME_W = 8;
    localparam int STILL_TIME_W = 16;
    localparam int LIMIT_HIGH_W = 3;
    localparam int SIGN_COPY_W = 4;
    localparam int SIGN_BIT = 11;
    localparam logic [7:0] MOTION_TIME_ONE = 8'h01;
    localparam logic [15:0] STILL_TIME_ONE = 16'h0001;

    // ****************************************************************
    // types
    // ****************************************************************
    typedef struct packed {
        logic [SAMPLE_W-1:0] x;
        logic [SAMPLE_W-1:0] y;
        logic [SAMPLE_W-1:0] z;
        logic [SAMPLE_W-1:0] temp;
    } mdr_sample_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } mdr_reg_req_t;

    typedef struct packed {
        logic [SAMPLE_W-1:0] y_data;
        logic [SAMPLE_W-1:0] z_data;
        logic [SAMPLE_W-1:0] temp_data;
        logic [LIMIT_W-1:0] motion_limit;
        logic [MOTION_TIME_W-1:0] motion_sample_count;
        logic [LIMIT_W-1:0] stillness_limit;
        logic [STILL_TIME_W-1:0] stillness_count;
        logic [MOTION_TIME_W-1:0] motion_run;
        logic [STILL_TIME_W-1:0] stillness_run;
        logic motion_flag;
        logic stillness_flag;
        logic standby;
        logic soft_reset_pulse;
        logic [7:0] rdata;
    } mdr_state_t;

    localparam mdr_state_t MDR_STATE_RESET = '{
        y_data: '0, z_data: '0, temp_data: '0,
        motion_limit: '0, motion_sample_count: '0,
        stillness_limit: '0, stillness_count: '0,
        motion_run: '0, stillness_run: '0,
        motion_flag: 1'b0, stillness_flag: 1'b0,
        standby: 1'b1, soft_reset_pulse: 1'b0, rdata: 8'h00
    };

endpackage

/* hdl/mdr_regs.sv */
// motion detect register bank: result registers, soft reset, activity and inactivity detectors
//
// Contract
// - y result 12 bits, low then high byte
// - high byte bits 15:12 copy bit 11
// - z result 12 bits, sign extended pair
// - temperature 12 bits, sign extended pair
// - code 0x52 resets settings, enters standby
// - soft reset floats interrupt pins
// - reset command reads back 0x00
// - activity compares axis magnitude with 11-bit limit
// - limit is low byte plus high bits 2:0
// - activity after programmed consecutive over-limit samples
// - activity time zero acts as one
// - wake-up mode uses single sample
// - inactivity compares axis magnitude with limit
// - inactivity after 16-bit count of still samples
// - stillness count is low and high bytes
// - counter reaches 0xffff without wrapping
// - inactivity time zero acts as one
// - timers advance once per output sample
// - set motion and stillness flags on detection
// - each detector runs only when enabled
`timescale 1ns/10ps

module mdr_regs
    import mdr_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    // register port
    input mdr_pkg::mdr_reg_req_t reg_req,
    output logic [7:0] reg_rdata,

    // sample stream
    input wire logic sample_valid,
    input mdr_pkg::mdr_sample_t sample,

    // detector controls
    input wire logic motion_detect_enable,
    input wire logic stillness_detect_enable,
    input wire logic wake_up_mode,
    input wire logic measure_start,
    input wire logic motion_flag_clear,
    input wire logic stillness_flag_clear,

    // flags, standby and interrupt pin
    output logic motion_flag,
    output logic stillness_flag,
    output logic standby,
    output logic soft_reset_pulse,
    output logic int_pin_out,
    output logic int_pin_oe
);
    import mdr_pkg::*;

    mdr_state_t st_r;
    mdr_state_t st_nxt;

    // whole bank in one struct: soft reset is a single load
    // of the reset constant, so no field can be missed
    // limitations:
    // - result pairs are not snapshotted; a sample landing
    //   between low and high reads can mix two samples
    // - a new count acts on the next sample, no restart needed
    // - an axis exactly at a limit is neither over nor under
    // - flags are sticky; a same-cycle clear loses to a set

    // ****************************************************************
    // helpers
    // ****************************************************************
    // 12-bit magnitude; -2048 needs the full 12 bits unsigned
    // negation wraps only for -2048, whose result 0x800
    // is still the right unsigned magnitude
    function automatic logic [SAMPLE_W-1:0] magnitude(input logic [SAMPLE_W-1:0] v);
        logic [SAMPLE_W-1:0] neg;
        neg = SAMPLE_W'(~v + SAMPLE_W'(1));
        magnitude = v[SIGN_BIT] ? neg : v;
    endfunction

    // upper byte of a pair: sign copies above bits 11:8,
    // shared so all three results extend alike
    function automatic logic [7:0] high_byte(input logic [SAMPLE_W-1:0] v);
        high_byte = {{SIGN_COPY_W{v[SIGN_BIT]}}, v[SAMPLE_W-1:8]};
    endfunction

    // read decode of the registered state; a write in the
    // same cycle is not yet visible
    function automatic logic [7:0] read_mux(input logic [7:0] a, input mdr_state_t s);
        if (a == ADDR_Y_ACCEL_LOW) begin
            read_mux = s.y_data[7:0];
        end else if (a == ADDR_Y_ACCEL_HIGH) begin
            read_mux = high_byte(s.y_data);
        end else if (a == ADDR_Z_ACCEL_LOW) begin
            read_mux = s.z_data[7:0];
        end else if (a == ADDR_Z_ACCEL_HIGH) begin
            read_mux = high_byte(s.z_data);
        end else if (a == ADDR_TEMPERATURE_LOW) begin
            read_mux = s.temp_data[7:0];
        end else if (a == ADDR_TEMPERATURE_HIGH) begin
            read_mux = high_byte(s.temp_data);
        end else if (a == ADDR_RESET_COMMAND) begin
            read_mux = READ_AS_ZERO;
        end else if (a == ADDR_MOTION_LIMIT_LOW) begin
            read_mux = s.motion_limit[7:0];
        end else if (a == ADDR_MOTION_LIMIT_HIGH) begin
            read_mux = {5'h00, s.motion_limit[LIMIT_W-1:8]};
        end else if (a == ADDR_MOTION_SAMPLE_COUNT) begin
            read_mux = s.motion_sample_count;
        end else if (a == ADDR_STILLNESS_LIMIT_LOW) begin
            read_mux = s.stillness_limit[7:0];
        end else if (a == ADDR_STILLNESS_LIMIT_HIGH) begin
            read_mux = {5'h00, s.stillness_limit[LIMIT_W-1:8]};
        end else if (a == ADDR_STILLNESS_COUNT_LOW) begin
            read_mux = s.stillness_count[7:0];
        end else if (a == ADDR_STILLNESS_COUNT_HIGH) begin
            read_mux = s.stillness_count[15:8];
        end else begin
            read_mux = READ_AS_ZERO;
        end
    endfunction

    // ****************************************************************
    // per-sample threshold tests
    // ****************************************************************
    localparam int AXES = 3;

    logic [SAMPLE_W-1:0] axis_val [AXES];
    logic [SAMPLE_W-1:0] axis_mag [AXES];
    logic [AXES-1:0] axis_over;
    logic [AXES-1:0] axis_under;
    logic [SAMPLE_W-1:0] motion_lim_ext;
    logic [SAMPLE_W-1:0] still_lim_ext;
    logic over_any;
    logic under_all;
    logic [MOTION_TIME_W-1:0] motion_target;
    logic [STILL_TIME_W-1:0] still_target;
    logic [MOTION_TIME_W:0] motion_sum;
    logic [STILL_TIME_W:0] still_sum;
    logic motion_hit;
    logic still_hit;

    assign axis_val[0] = sample.x;
    assign axis_val[1] = sample.y;
    assign axis_val[2] = sample.z;

    // limits are unsigned; a leading zero keeps the compare unsigned
    assign motion_lim_ext = {1'b0, st_r.motion_limit};
    assign still_lim_ext = {1'b0, st_r.stillness_limit};

    // one magnitude and two compares per axis
    genvar g;
    generate
        for (g = 0; g < AXES; g = g + 1) begin : g_axis
            assign axis_mag[g] = magnitude(axis_val[g]);
            assign axis_over[g] = axis_mag[g] > motion_lim_ext;
            assign axis_under[g] = axis_mag[g] < still_lim_ext;
        end
    endgenerate

    // motion needs one axis over; stillness needs every axis under
    assign over_any = |axis_over;
    assign under_all = &axis_under;

    // zero behaves as one; wake-up mode forces a single sample
    // targets follow the registers every cycle, so a new
    // count applies from the next sample on
    always_comb begin
        if (wake_up_mode || st_r.motion_sample_count == '0) begin
            motion_target = MOTION_TIME_ONE;
        end else begin
            motion_target = st_r.motion_sample_count;
        end
        if (st_r.stillness_count == '0) begin
            still_target = STILL_TIME_ONE;
        end else begin
            still_target = st_r.stillness_count;
        end
    end

    // one bit wider than the run: a target of 0xff or 0xffff
    // is met without the increment wrapping to zero
    assign motion_sum = {1'b0, st_r.motion_run} + (MOTION_TIME_W + 1)'(1);
    assign still_sum = {1'b0, st_r.stillness_run} + (STILL_TIME_W + 1)'(1);
    assign motion_hit = motion_sum >= {1'b0, motion_target};
    assign still_hit = still_sum >= {1'b0, still_target};

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        st_nxt = st_r;
        st_nxt.soft_reset_pulse = 1'b0;

        // read data is captured once and stands until the next read or a soft reset
        if (reg_req.rd) begin
            st_nxt.rdata = read_mux(reg_req.addr, st_r);
        end

        // the power control that ends standby sits outside the bank
        if (measure_start) begin
            st_nxt.standby = 1'b0;
        end

        // flags: hardware set wins over a clear in the same cycle,
        // because the detectors below assign after the clears
        if (motion_flag_clear) begin
            st_nxt.motion_flag = 1'b0;
        end
        if (stillness_flag_clear) begin
            st_nxt.stillness_flag = 1'b0;
        end

        // detectors only look at a sample while measuring;
        // in standby the result registers keep their value
        if (sample_valid && !st_r.standby) begin
            st_nxt.y_data = sample.y;
            st_nxt.z_data = sample.z;
            st_nxt.temp_data = sample.temp;

            // activity: consecutive samples with any axis over the limit
            if (motion_detect_enable) begin
                if (!over_any) begin
                    st_nxt.motion_run = '0;
                end else if (motion_hit) begin
                    // hold at target: each further over-limit sample sets the flag again
                    st_nxt.motion_run = motion_target;
                    st_nxt.motion_flag = 1'b1;
                end else begin
                    st_nxt.motion_run = motion_sum[MOTION_TIME_W-1:0];
                end
            end else begin
                // a disabled detector restarts from zero
                st_nxt.motion_run = '0;
            end

            // inactivity: consecutive samples with every axis under the limit
            if (stillness_detect_enable) begin
                if (!under_all) begin
                    st_nxt.stillness_run = '0;
                end else if (still_hit) begin
                    // hold at target, which is at most 0xffff
                    st_nxt.stillness_run = still_target;
                    st_nxt.stillness_flag = 1'b1;
                end else begin
                    st_nxt.stillness_run = still_sum[STILL_TIME_W-1:0];
                end
            end else begin
                // a disabled detector restarts from zero
                st_nxt.stillness_run = '0;
            end
        end

        // writes to result registers and unmapped addresses fall through
        if (reg_req.wr) begin
            if (reg_req.addr == ADDR_MOTION_LIMIT_LOW) begin
                st_nxt.motion_limit[7:0] = reg_req.wdata;
            end else if (reg_req.addr == ADDR_MOTION_LIMIT_HIGH) begin
                st_nxt.motion_limit[LIMIT_W-1:8] = reg_req.wdata[LIMIT_HIGH_W-1:0];
            end else if (reg_req.addr == ADDR_MOTION_SAMPLE_COUNT) begin
                st_nxt.motion_sample_count = reg_req.wdata;
            end else if (reg_req.addr == ADDR_STILLNESS_LIMIT_LOW) begin
                st_nxt.stillness_limit[7:0] = reg_req.wdata;
            end else if (reg_req.addr == ADDR_STILLNESS_LIMIT_HIGH) begin
                st_nxt.stillness_limit[LIMIT_W-1:8] = reg_req.wdata[LIMIT_HIGH_W-1:0];
            end else if (reg_req.addr == ADDR_STILLNESS_COUNT_LOW) begin
                st_nxt.stillness_count[7:0] = reg_req.wdata;
            end else if (reg_req.addr == ADDR_STILLNESS_COUNT_HIGH) begin
                st_nxt.stillness_count[15:8] = reg_req.wdata;
            end
        end

        // soft reset overrides everything else in this cycle; other codes fall through
        if (reg_req.wr && reg_req.addr == ADDR_RESET_COMMAND &&
            reg_req.wdata == SOFT_RESET_CODE) begin
            st_nxt = MDR_STATE_RESET;
            st_nxt.soft_reset_pulse = 1'b1;
        end
    end

    // synchronous reset only; soft reset loads the same constant
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_r <= MDR_STATE_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign reg_rdata = st_r.rdata;
    assign motion_flag = st_r.motion_flag;
    assign stillness_flag = st_r.stillness_flag;
    assign standby = st_r.standby;
    assign soft_reset_pulse = st_r.soft_reset_pulse;
    // pin level is high while either sticky flag stands
    assign int_pin_out = st_r.motion_flag | st_r.stillness_flag;
    // pin floats in standby; external keepers hold its level
    assign int_pin_oe = ~st_r.standby;

endmodule

/* tb/mdr_host.sv */
// host model driving the register port
`timescale 1ns/10ps
module mdr_host
    import mdr_pkg::*;
(
    input wire logic clk,
    output mdr_pkg::mdr_reg_req_t reg_req,
    input wire logic [7:0] reg_rdata
);
    // ****************************************************************
    // register cycles
    // ****************************************************************
    initial reg_req = '0;
    // released fields show inverted values so stale data cannot pass
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_req = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(negedge clk);
        reg_req = '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
        if (a == ADDR_RESET_COMMAND && d == SOFT_RESET_CODE) repeat (20000) @(negedge clk);
    endtask
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        reg_req = '{addr: a, wdata: ~a, wr: 1'b0, rd: 1'b1};
        @(negedge clk);
        reg_req = '{addr: ~a, wdata: a, wr: 1'b0, rd: 1'b0};
        d = reg_rdata;
    endtask
endmodule

/* tb/mdr_monitor.sv */
// concurrent checks on the register bank ports
`timescale 1ns/10ps
module mdr_monitor
    import mdr_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input mdr_pkg::mdr_reg_req_t reg_req,
    input wire logic [7:0] reg_rdata,
    input wire logic sample_valid,
    input wire logic motion_detect_enable,
    input wire logic motion_flag_clear,
    input wire logic motion_flag,
    input wire logic stillness_flag,
    input wire logic standby,
    input wire logic soft_reset_pulse,
    input wire logic int_pin_oe
);
    // ****************************************************************
    // port relations
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic srst_wr;
    assign srst_wr = reg_req.wr && reg_req.addr == ADDR_RESET_COMMAND;
    AST_SOFT_RESET: assert property (srst_wr && reg_req.wdata == SOFT_RESET_CODE |=>
        soft_reset_pulse && standby && !motion_flag && !stillness_flag)
        else $error("soft reset code did not reset");
    AST_OTHER_CODE: assert property (srst_wr && reg_req.wdata != SOFT_RESET_CODE |=>
        !soft_reset_pulse) else $error("soft reset on wrong code");
    AST_PIN_FLOAT: assert property (int_pin_oe == !standby)
        else $error("interrupt pin driven in standby");
    AST_READ_ZERO: assert property (reg_req.rd && reg_req.addr == ADDR_RESET_COMMAND |=>
        reg_rdata == READ_AS_ZERO) else $error("reset command read not zero");
    AST_SIGN_COPY: assert property (reg_req.rd && reg_req.addr inside {8'h11, 8'h13, 8'h15}
        |=> reg_rdata[7:4] == {4{reg_rdata[3]}}) else $error("upper bits not sign copies");
    AST_PER_SAMPLE: assert property ($rose(motion_flag) || $rose(stillness_flag) |->
        $past(sample_valid)) else $error("flag rose without a sample");
    AST_ENABLED: assert property ($rose(motion_flag) |-> $past(motion_detect_enable))
        else $error("activity flag while disabled");
    AST_STICKY: assert property (motion_flag && !motion_flag_clear && !srst_wr |=>
        motion_flag) else $error("activity flag dropped without clear");
endmodule

bind mdr_regs mdr_monitor u_mon (.clk(clk), .sys_rst(sys_rst), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .sample_valid(sample_valid),
    .motion_detect_enable(motion_detect_enable), .motion_flag_clear(motion_flag_clear),
    .motion_flag(motion_flag), .stillness_flag(stillness_flag), .standby(standby),
    .soft_reset_pulse(soft_reset_pulse), .int_pin_oe(int_pin_oe));

/* tb/tb.sv */
// self-checking testbench of the motion detect register bank
`timescale 1ns/10ps
module tb;
    import mdr_pkg::*;
    logic clk, sys_rst, sample_valid, wake_up_mode, measure_start, int_pin_out, int_pin_oe;
    logic motion_detect_enable, stillness_detect_enable, motion_flag_clear, stillness_flag_clear;
    logic motion_flag, stillness_flag, standby, soft_reset_pulse;
    logic [7:0] reg_rdata, rv, d;
    logic [11:0] y, z, t;
    logic [31:0] seed = 32'hf024dcb3;
    mdr_reg_req_t reg_req;
    mdr_sample_t sample;
    int err_count = 0, comparisons = 0, cycles = 0;
    mdr_regs dut (.clk(clk), .sys_rst(sys_rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .sample_valid(sample_valid), .sample(sample), .motion_detect_enable(motion_detect_enable),
        .stillness_detect_enable(stillness_detect_enable), .wake_up_mode(wake_up_mode),
        .measure_start(measure_start), .motion_flag_clear(motion_flag_clear),
        .stillness_flag_clear(stillness_flag_clear), .motion_flag(motion_flag),
        .stillness_flag(stillness_flag), .standby(standby), .soft_reset_pulse(soft_reset_pulse),
        .int_pin_out(int_pin_out), .int_pin_oe(int_pin_oe));
    mdr_host host (.clk(clk), .reg_req(reg_req), .reg_rdata(reg_rdata));
    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [7:0] hi_byte(input logic [11:0] v);
        return {{4{v[11]}}, v[11:8]};
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        host.read_reg(a, rv);
        check(rv, exp);
    endtask
    task automatic samp(input logic [11:0] sx, input logic [11:0] sy, input logic [11:0] sz);
        @(negedge clk);
        sample = '{x: sx, y: sy, z: sz, temp: t};
        sample_valid = 1'b1;
        @(negedge clk);
        sample_valid = 1'b0;
        sample = ~sample;
    endtask
    task automatic clr();
        @(negedge clk);
        {motion_flag_clear, stillness_flag_clear} = 2'h3;
        @(negedge clk);
        {motion_flag_clear, stillness_flag_clear} = 2'h0;
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            err_count++;
            print_verdict();
        end
    end
    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        {sys_rst, sample_valid, wake_up_mode, measure_start} = 4'h8;
        {motion_detect_enable, stillness_detect_enable, motion_flag_clear} = 3'h0;
        {stillness_flag_clear, sample, t} = '0;
        repeat (2) @(negedge clk);
        sys_rst = 1'b0;
        for (int a = 'h10; a <= 'h27; a++) rchk(8'(a), 8'h00);
        check(standby, 1'b1);
        check(int_pin_oe, 1'b0);
        $display("reset values done");
        for (int a = 'h20; a <= 'h26; a++) begin
            d = 8'(rnd());
            host.write_reg(8'(a), d);
            rchk(8'(a), (a == 'h21 || a == 'h24) ? (d & 8'h07) : d);
        end
        host.write_reg(ADDR_RESET_COMMAND, 8'h53);
        rchk(ADDR_STILLNESS_COUNT_HIGH, d);
        rchk(ADDR_RESET_COMMAND, 8'h00);
        $display("access test done");
        @(negedge clk) measure_start = 1'b1;
        @(negedge clk) measure_start = 1'b0;
        check(int_pin_oe, 1'b1);
        for (int i = 0; i < 8; i++) begin
            y = (i == 0) ? 12'h800 : 12'(rnd());
            z = (i == 0) ? 12'h7ff : 12'(rnd());
            t = 12'(rnd());
            samp(12'(rnd()), y, z);
            rchk(ADDR_Y_ACCEL_LOW, y[7:0]);
            rchk(ADDR_Y_ACCEL_HIGH, hi_byte(y));
            rchk(ADDR_Z_ACCEL_LOW, z[7:0]);
            rchk(ADDR_Z_ACCEL_HIGH, hi_byte(z));
            rchk(ADDR_TEMPERATURE_LOW, t[7:0]);
            rchk(ADDR_TEMPERATURE_HIGH, hi_byte(t));
        end
        $display("result test done");
        host.write_reg(ADDR_MOTION_LIMIT_LOW, 8'h10);
        host.write_reg(ADDR_MOTION_LIMIT_HIGH, 8'h00);
        host.write_reg(ADDR_MOTION_SAMPLE_COUNT, 8'h02);
        motion_detect_enable = 1'b1;
        clr();
        samp(12'h020, 12'h000, 12'h000);
        check(motion_flag, 1'b0);
        samp(12'h000, 12'hfe0, 12'h000);
        check(motion_flag, 1'b1);
        check(int_pin_out, 1'b1);
        samp(12'h010, 12'h010, 12'hff0);
        clr();
        samp(12'h020, 12'h000, 12'h000);
        samp(12'h010, 12'h010, 12'hff0);
        samp(12'h020, 12'h000, 12'h000);
        check(motion_flag, 1'b0);
        host.write_reg(ADDR_MOTION_SAMPLE_COUNT, 8'h00);
        samp(12'h010, 12'h000, 12'h000);
        samp(12'h000, 12'h000, 12'h011);
        check(motion_flag, 1'b1);
        host.write_reg(ADDR_MOTION_SAMPLE_COUNT, 8'h03);
        wake_up_mode = 1'b1;
        clr();
        samp(12'h000, 12'h000, 12'h7ff);
        check(motion_flag, 1'b1);
        motion_detect_enable = 1'b0;
        clr();
        samp(12'h7ff, 12'h000, 12'h000);
        check(motion_flag, 1'b0);
        $display("activity test done");
        host.write_reg(ADDR_STILLNESS_LIMIT_LOW, 8'h10);
        host.write_reg(ADDR_STILLNESS_LIMIT_HIGH, 8'h00);
        host.write_reg(ADDR_STILLNESS_COUNT_LOW, 8'h00);
        host.write_reg(ADDR_STILLNESS_COUNT_HIGH, 8'h01);
        stillness_detect_enable = 1'b1;
        clr();
        repeat (255) samp(12'h00f, 12'hff1, 12'h000);
        check(stillness_flag, 1'b0);
        samp(12'h000, 12'h000, 12'h00f);
        check(stillness_flag, 1'b1);
        host.write_reg(ADDR_STILLNESS_COUNT_HIGH, 8'h00);
        samp(12'h7ff, 12'h000, 12'h000);
        clr();
        samp(12'h000, 12'h000, 12'h000);
        check(stillness_flag, 1'b1);
        $display("inactivity test done");
        host.write_reg(ADDR_RESET_COMMAND, SOFT_RESET_CODE);
        check(standby, 1'b1);
        check(int_pin_oe, 1'b0);
        check(stillness_flag, 1'b0);
        check(int_pin_out, 1'b0);
        rchk(ADDR_MOTION_LIMIT_LOW, 8'h00);
        rchk(ADDR_Z_ACCEL_HIGH, 8'h00);
        $display("soft reset test done");
        print_verdict();
    end
endmodule
